// ==== logic/sctl_core.v ====
// system clock source selection, divisors, watchdog and regulator resets with APB registers
// Notes on behaviour
// - watchdog interrupt first, reset second time-out
// - after first time-out reload from load value
// - reset only if interrupt uncleared and enabled
// - second time-out pulses internal reset, then releases
// - regulator fault sets flag and pulses reset
// - regulator reset disabled until software enables
// - trim field steps regulator 2.25 to 2.75
// - clock from main, internal, internal/4, PLL
// - source codes main 0, internal 1, quarter 2
// - skip bit picks oscillator, else PLL
// - system divider divides by field plus one, code 0 by two off the oscillator
// - low codes reserved with PLL; reset 0xF
// - ADC clock divided down to 16.67 MHz
// - PWM clock synchronous division of system clock
// - every peripheral has its own clock gate
// - clock register holds enables, divisors, crystal, sleep
// - crystal number passed to PLL setting with main source, else source code
// - 0x1200 main-osc count blocks unstable PLL
`timescale 1ns/100ps
`include "sctl_regs.vh"
module sctl_core #(
  parameter NPERIPH = 8
) (
  // clock and reset
  input  wire               clk,
  input  wire               rst,
  // APB slave
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [7:0]         paddr,
  input  wire [31:0]        pwdata,
  output wire               pready,
  output reg  [31:0]        prdata,
  output reg                pslverr,
  // oscillator and PLL clocks from the pins, sampled as levels
  input  wire               mainOscIn,
  input  wire               intOscIn,
  input  wire               pllClkIn,
  // regulator status and trim
  input  wire               regOutOfRange,
  output wire [3:0]         regulatorVoltageTrim,
  // PLL control
  output wire               pllPowerDown,
  output reg  [3:0]         pllRefSetting,
  output wire               pllReady,
  // clock enables and sleep source
  output wire               systemClockEn,
  output wire [NPERIPH-1:0] periphClockEn,
  output wire               adcClockEn,
  output wire               pwmClockEn,
  output wire [1:0]         sleepSource,
  // watchdog interrupt and internal reset
  output wire               wdtInterrupt,
  output wire               internalReset
);
  // register state, synchronisers and combinational helpers
  reg  [31:0]        wdLoad_reg;
  reg  [1:0]         wdCtl_reg;
  reg                wdFlag_reg;
  reg  [31:0]        wdCnt_reg;
  reg  [3:0]         ldoTrim_reg;
  reg                ldoRstEn_reg;
  reg  [1:0]         resCause_reg;
  reg  [31:0]        rcc_reg;
  reg  [NPERIPH-1:0] gate_reg;
  reg  [15:0]        pllCnt_reg;
  reg  [1:0]         srcSel_reg;
  reg                usePll_reg;
  reg  [7:0]         rstHold_reg;
  reg  [2:0]         mainSync_reg;
  reg  [2:0]         intSync_reg;
  reg  [2:0]         pllSync_reg;
  reg  [1:0]         faultSync_reg;
  reg                intQuarter_reg;
  reg  [1:0]         quarterCnt_reg;
  reg  [3:0]         trim_next;
  reg                srcTick;
  reg  [31:0]        rdData;
  reg                rdHit;

  // bus phases, clock register fields, source ticks and reset requests
  wire       setupPh   = psel & ~penable;
  wire       wrEn      = psel & penable & pwrite;
  wire [1:0] osc_source_select    = rcc_reg[`SCTL_RCC_SRC_HI:`SCTL_RCC_SRC_LO];
  wire [3:0] xtalSel   = rcc_reg[`SCTL_RCC_CRYSTAL_SELECT_HI:`SCTL_RCC_CRYSTAL_SELECT_LO];
  wire [3:0] sysDivSet = rcc_reg[`SCTL_RCC_SDIV_HI:`SCTL_RCC_SDIV_LO];
  wire [2:0] pwmDivSet = rcc_reg[`SCTL_RCC_PWM_HI:`SCTL_RCC_PWM_LO];
  wire       bypass    = rcc_reg[`SCTL_RCC_BYPASS];
  wire       mainTick  = mainSync_reg[1] & ~mainSync_reg[2] & ~rcc_reg[`SCTL_RCC_MOSCDIS];
  wire       intTick   = intSync_reg[1] & ~intSync_reg[2] & ~rcc_reg[`SCTL_RCC_IOSCDIS];
  wire       pllTick   = pllSync_reg[1] & ~pllSync_reg[2] & ~pllPowerDown;
  wire       wdZero    = (wdCnt_reg == 32'h00000000);
  wire       wdStep    = systemClockEn & wdCtl_reg[`SCTL_WDCTL_INTEN];
  wire       wdTimeout = wdStep & wdZero;
  wire       wdReset   = wdTimeout & wdFlag_reg & wdCtl_reg[`SCTL_WDCTL_RESEN];
  wire       ldoReset  = faultSync_reg[1] & ldoRstEn_reg;
  wire       sysWrap;
  wire [3:0] sysDivEff;
  wire       pwmTick;
  wire       wrRcc     = wrEn & (paddr == `SCTL_RCC_OFF);

  // two-flop samplers for every pin input; a third stage on the clock pins only feeds edge detection
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mainSync_reg  <= 3'h0;
      intSync_reg   <= 3'h0;
      pllSync_reg   <= 3'h0;
      faultSync_reg <= 2'h0;
    end else begin
      mainSync_reg  <= {mainSync_reg[1:0], mainOscIn};
      intSync_reg   <= {intSync_reg[1:0], intOscIn};
      pllSync_reg   <= {pllSync_reg[1:0], pllClkIn};
      faultSync_reg <= {faultSync_reg[0], regOutOfRange};
    end
  end

  // internal oscillator divided by four
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      quarterCnt_reg <= 2'h0;
      intQuarter_reg <= 1'b0;
    end else begin
      intQuarter_reg <= 1'b0;
      if (intTick) begin
        quarterCnt_reg <= quarterCnt_reg + 2'h1;
        intQuarter_reg <= (quarterCnt_reg == 2'h3);
      end
    end
  end

  // PLL settling counter, run from main oscillator ticks
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pllCnt_reg <= `SCTL_PLL_READY;
    end else if (wrRcc && ((pwdata[`SCTL_RCC_CRYSTAL_SELECT_HI:`SCTL_RCC_CRYSTAL_SELECT_LO] != xtalSel) ||
                 (pllPowerDown && !pwdata[`SCTL_RCC_PWRDN]))) begin
      pllCnt_reg <= `SCTL_PLL_READY;
    end else if (mainTick && pllCnt_reg != 16'h0000) begin
      pllCnt_reg <= pllCnt_reg - 16'h0001;
    end
  end

  // PLL usable only once settled and powered; sleep source passes straight out
  assign pllReady     = (pllCnt_reg == 16'h0000) & ~pllPowerDown;
  assign pllPowerDown = rcc_reg[`SCTL_RCC_PWRDN];
  assign sleepSource  = rcc_reg[`SCTL_RCC_SLP_HI:`SCTL_RCC_SLP_LO];

  // crystal number to PLL reference setting with the main source, source code otherwise, refreshed on every change
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pllRefSetting <= 4'h0;
    end else if (osc_source_select == `SCTL_SRC_MAIN) begin
      pllRefSetting <= xtalSel;
    end else begin
      pllRefSetting <= {2'h0, osc_source_select};
    end
  end

  // active source: changed only when the divider sits at its period boundary
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      srcSel_reg <= `SCTL_SRC_MAIN;
      usePll_reg <= 1'b0;
    end else if (sysWrap) begin
      srcSel_reg <= osc_source_select;
      usePll_reg <= ~bypass & pllReady;
    end
  end

  // source tick multiplexer
  always @* begin
    if (usePll_reg) begin
      srcTick = pllTick;
    end else begin
      case (srcSel_reg)
        `SCTL_SRC_MAIN: srcTick = mainTick;
        `SCTL_SRC_INT:  srcTick = intTick;
        `SCTL_SRC_INT4: srcTick = intQuarter_reg;
        default:        srcTick = mainTick;
      endcase
    end
  end

  // code zero still divides by two when the oscillator feeds the divider
  assign sysDivEff = (!usePll_reg && sysDivSet == 4'h0) ? 4'h1 : sysDivSet;

  // system clock divider
  sctl_tick_div #(.W(4)) system_divisor (
    .clk     (clk),
    .rst     (rst),
    .tickIn  (srcTick),
    .divisor (sysDivEff),
    .tickOut (systemClockEn),
    .wrap    (sysWrap)
  );

  // ADC clock from the PLL, fixed ratio
  sctl_tick_div #(.W(4)) adcDiv (
    .clk     (clk),
    .rst     (rst),
    .tickIn  (pllTick),
    .divisor (`SCTL_ADC_DIV),
    .tickOut (adcClockEn),
    .wrap    ()
  );

  // PWM clock as power-of-two division of the system clock
  sctl_tick_div #(.W(8)) pwm_clock_divisor (
    .clk     (clk),
    .rst     (rst),
    .tickIn  (systemClockEn),
    .divisor ((8'h02 << pwmDivSet) - 8'h01),
    .tickOut (pwmTick),
    .wrap    ()
  );

  // pwm enable follows its divider only while the use bit is set
  assign pwmClockEn    = rcc_reg[`SCTL_RCC_USEPWM] ? pwmTick : systemClockEn;
  assign periphClockEn = gate_reg & {NPERIPH{systemClockEn}};

  // watchdog counter and first time-out flag
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wdCnt_reg  <= `SCTL_WD_LOAD_RST;
      wdFlag_reg <= 1'b0;
    end else if (internalReset) begin
      wdCnt_reg  <= wdLoad_reg;
      wdFlag_reg <= 1'b0;
    end else begin
      if (wrEn && paddr == `SCTL_WDLOAD_OFF) begin
        wdCnt_reg <= pwdata;
      end else if (wdTimeout) begin
        wdCnt_reg <= wdLoad_reg;
      end else if (wdStep) begin
        wdCnt_reg <= wdCnt_reg - 32'h00000001;
      end
      // a time-out in the clearing cycle keeps the flag set
      if (wdTimeout) begin
        wdFlag_reg <= 1'b1;
      end else if (wrEn && paddr == `SCTL_WDSTAT_OFF && pwdata[0]) begin
        wdFlag_reg <= 1'b0;
      end
    end
  end

  // the first time-out flag is the interrupt line itself
  assign wdtInterrupt = wdFlag_reg;

  // internal reset stretch and reset cause flags
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rstHold_reg  <= 8'h00;
      resCause_reg <= 2'h0;
    end else begin
      if (wdReset || ldoReset) begin
        rstHold_reg <= `SCTL_RST_HOLD;
      end else if (rstHold_reg != 8'h00) begin
        rstHold_reg <= rstHold_reg - 8'h01;
      end
      resCause_reg[`SCTL_RESC_WDT] <= wdReset |
        (resCause_reg[`SCTL_RESC_WDT] & ~(wrEn && paddr == `SCTL_RESC_OFF &&
        pwdata[`SCTL_RESC_WDT]));
      resCause_reg[`SCTL_RESC_LDO] <= ldoReset |
        (resCause_reg[`SCTL_RESC_LDO] & ~(wrEn && paddr == `SCTL_RESC_OFF &&
        pwdata[`SCTL_RESC_LDO]));
    end
  end

  // core and peripherals stay in reset while the hold count runs
  assign internalReset = (rstHold_reg != 8'h00);

  // regulator trim written above the top step is held at the top step
  always @* begin
    trim_next = pwdata[`SCTL_LDO_TRIM_HI:`SCTL_LDO_TRIM_LO];
    if (trim_next > `SCTL_LDO_TRIM_MAX) begin
      trim_next = `SCTL_LDO_TRIM_MAX;
    end
  end

  // trim step code goes straight to the regulator
  assign regulatorVoltageTrim = ldoTrim_reg;

  // software-written registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wdLoad_reg   <= `SCTL_WD_LOAD_RST;
      wdCtl_reg    <= 2'h0;
      ldoTrim_reg  <= 4'h0;
      ldoRstEn_reg <= 1'b0;
      rcc_reg      <= `SCTL_RCC_RESET;
      gate_reg     <= {NPERIPH{1'b0}};
    end else if (wrEn) begin
      case (paddr)
        `SCTL_WDLOAD_OFF: wdLoad_reg <= pwdata;
        `SCTL_WDCTL_OFF:  wdCtl_reg <= pwdata[1:0];
        `SCTL_LDOCTL_OFF: begin
          ldoTrim_reg  <= trim_next;
          ldoRstEn_reg <= pwdata[`SCTL_LDO_RSTEN];
        end
        `SCTL_RCC_OFF:    rcc_reg <= pwdata;
        `SCTL_PGATE_OFF:  gate_reg <= pwdata[NPERIPH-1:0];
        default:          wdLoad_reg <= wdLoad_reg;
      endcase
    end
  end

  // read multiplexer and address decode
  always @* begin
    rdData = 32'h00000000;
    rdHit  = 1'b1;
    case (paddr)
      `SCTL_WDLOAD_OFF:  rdData = wdLoad_reg;
      `SCTL_WDCTL_OFF:   rdData = {30'h0, wdCtl_reg};
      `SCTL_WDSTAT_OFF:  rdData = {31'h0, wdFlag_reg};
      `SCTL_WDVAL_OFF:   rdData = wdCnt_reg;
      `SCTL_LDOCTL_OFF:  rdData = {23'h0, ldoRstEn_reg, 4'h0, ldoTrim_reg};
      `SCTL_RESC_OFF:    rdData = {30'h0, resCause_reg};
      `SCTL_RCC_OFF:     rdData = rcc_reg;
      `SCTL_PGATE_OFF:   rdData = {{(32-NPERIPH){1'b0}}, gate_reg};
      `SCTL_PLLSTAT_OFF: rdData = {usePll_reg, 15'h0, pllCnt_reg[14:0], pllReady};
      default:           rdHit  = 1'b0;
    endcase
  end

  // read data and error captured in the setup cycle, shown in the access cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setupPh) begin
      prdata  <= pwrite ? 32'h00000000 : rdData;
      pslverr <= ~rdHit;
    end
  end

  // no wait states: every access phase completes at once
  assign pready = 1'b1;
endmodule

// ==== logic/sctl_regs.vh ====
// register offsets, field positions, reset values and timing counts of the system control block
`ifndef SCTL_REGS_VH
`define SCTL_REGS_VH

// register byte offsets
`define SCTL_WDLOAD_OFF   8'h00
`define SCTL_WDCTL_OFF    8'h04
`define SCTL_WDSTAT_OFF   8'h08
`define SCTL_WDVAL_OFF    8'h0c
`define SCTL_LDOCTL_OFF   8'h10
`define SCTL_RESC_OFF     8'h14
`define SCTL_RCC_OFF      8'h18
`define SCTL_PGATE_OFF    8'h1c
`define SCTL_PLLSTAT_OFF  8'h20

// watchdog control bits
`define SCTL_WDCTL_INTEN  0
`define SCTL_WDCTL_RESEN  1

// reset cause bits
`define SCTL_RESC_WDT     0
`define SCTL_RESC_LDO     1

// regulator control fields
`define SCTL_LDO_TRIM_HI  3
`define SCTL_LDO_TRIM_LO  0
`define SCTL_LDO_RSTEN    8
`define SCTL_LDO_TRIM_MAX 4'ha

// run-mode clock register fields
`define SCTL_RCC_MOSCDIS  0
`define SCTL_RCC_IOSCDIS  1
`define SCTL_RCC_SRC_HI   5
`define SCTL_RCC_SRC_LO   4
`define SCTL_RCC_CRYSTAL_SELECT_HI  9
`define SCTL_RCC_CRYSTAL_SELECT_LO  6
`define SCTL_RCC_BYPASS   11
`define SCTL_RCC_PWRDN    13
`define SCTL_RCC_PWM_HI   19
`define SCTL_RCC_PWM_LO   17
`define SCTL_RCC_USEPWM   20
`define SCTL_RCC_SDIV_HI  26
`define SCTL_RCC_SDIV_LO  23
`define SCTL_RCC_SLP_HI   29
`define SCTL_RCC_SLP_LO   28
`define SCTL_RCC_RESET    32'h07802a40

// oscillator source codes
`define SCTL_SRC_MAIN     2'h0
`define SCTL_SRC_INT      2'h1
`define SCTL_SRC_INT4     2'h2

// timing counts
`define SCTL_PLL_READY    16'h1200
`define SCTL_RST_HOLD     8'h10
`define SCTL_ADC_DIV      4'hb
`define SCTL_WD_LOAD_RST  32'hffffffff
`endif

// ==== logic/sctl_tick_div.v ====
// tick divider: one output pulse for every divisor+1 input pulses
`timescale 1ns/100ps
module sctl_tick_div #(
  parameter W = 4
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // tick in, divide setting, tick out
  input  wire         tickIn,
  input  wire [W-1:0] divisor,
  output wire         tickOut,
  output wire         wrap
);
  reg [W-1:0] cnt_reg;
  reg [W-1:0] div_reg;

  // setting taken only at a period boundary so no period is ever cut short
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= {W{1'b1}}; // reset sits on a boundary so the first tick loads the live setting
      div_reg <= {W{1'b0}};
    end else if (tickIn) begin
      if (cnt_reg >= div_reg) begin
        cnt_reg <= {W{1'b0}};
        div_reg <= divisor;
      end else begin
        cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign wrap    = (cnt_reg >= div_reg);
  assign tickOut = tickIn & wrap;
endmodule

// ==== tb/sctl_chk.sv ====
// port assertions for the system control block
`timescale 1ns/100ps
module sctl_chk #(parameter NPERIPH = 8) (
  // clock, reset and bus
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic [7:0]         paddr,
  input wire logic               pready,
  input wire logic               pslverr,
  // clocks and resets out
  input wire logic               systemClockEn,
  input wire logic [NPERIPH-1:0] periphClockEn,
  input wire logic               pwmClockEn,
  input wire logic               adcClockEn,
  input wire logic               pllReady,
  input wire logic               pllPowerDown,
  input wire logic [3:0]         regulatorVoltageTrim,
  input wire logic               wdtInterrupt,
  input wire logic               internalReset
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] hiCnt;
  // length of the running internal reset pulse, saturating
  always @(posedge clk or posedge rst)
    if (rst) hiCnt <= 8'h00;
    else hiCnt <= internalReset ? hiCnt + {7'h00, hiCnt != 8'hff} : 8'h00;
  a_bus_ready: assert property (pready) else $error("bus not ready");
  a_unmapped_err: assert property (psel && !penable && paddr > 8'h20 |=> pslverr)
    else $error("no error on unmapped address");
  a_mapped_ok: assert property (psel && !penable && paddr <= 8'h20 && paddr[1:0] == 2'h0
    |=> !pslverr) else $error("error on mapped address");
  a_reset_len: assert property ($fell(internalReset) |-> hiCnt >= 8'h10)
    else $error("internal reset too short");
  a_reset_clears: assert property (internalReset |=> !wdtInterrupt)
    else $error("watchdog flag kept over reset");
  a_gate_sync: assert property (|periphClockEn |-> systemClockEn)
    else $error("peripheral enable without system clock");
  a_pwm_sync: assert property (pwmClockEn |-> systemClockEn)
    else $error("pwm enable off system clock");
  a_sys_gap: assert property (systemClockEn |=> !systemClockEn)
    else $error("system clock divides below two");
  a_adc_gap: assert property (adcClockEn |=> !adcClockEn [*8])
    else $error("adc clock too fast");
  a_trim_max: assert property (regulatorVoltageTrim <= 4'ha)
    else $error("trim beyond top step");
  a_pll_power: assert property (pllReady |-> !pllPowerDown)
    else $error("pll ready while powered down");
endmodule
bind sctl_core sctl_chk #(.NPERIPH(NPERIPH)) i_chk (.*);

// ==== tb/sctl_core_tb_top.sv ====
// self-checking bench for the system control block
`timescale 1ns/100ps
`include "sctl_regs.vh"
module sctl_core_tb_top;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        regOutOfRange = 1'b0, pready, pslverr, err, mainOsc, intOsc, pllClk;
  logic        pllPowerDown, pllReady, sysEn, adcEn, pwmEn, wdtInt, intRst;
  logic [7:0]  paddr = 8'h00, pEn;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  trim, pllRef;
  logic [1:0]  slp;
  int          n_mismatch = 0, checks_done = 0, cyc = 0, p;
  // 100 MHz clock
  always #5 clk = ~clk;
  sctl_osc_model i_osc (.clk(clk), .pllPowerDown(pllPowerDown), .mainOsc(mainOsc),
    .intOsc(intOsc), .pllClk(pllClk));
  sctl_core i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mainOscIn(mainOsc), .intOscIn(intOsc), .pllClkIn(pllClk), .regOutOfRange(regOutOfRange),
    .regulatorVoltageTrim(trim), .pllPowerDown(pllPowerDown), .pllRefSetting(pllRef),
    .pllReady(pllReady), .systemClockEn(sysEn), .periphClockEn(pEn), .adcClockEn(adcEn),
    .pwmClockEn(pwmEn), .sleepSource(slp), .wdtInterrupt(wdtInt), .internalReset(intRst));
  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // one apb transfer, request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  function automatic logic sel(int k);
    case (k)
      0: return sysEn;
      1: return pwmEn;
      2: return wdtInt;
      3: return intRst;
      4: return !intRst;
      6: return adcEn;
      default: return pllReady;
    endcase
  endfunction
  // cycles until the chosen signal is seen high
  task automatic till(input int k, lim);
    p = 0;
    do begin @(posedge clk); #1; p++; end while (sel(k) !== 1'b1 && p < lim);
    if (p >= lim) chk(0, 1);
  endtask
  task automatic per(input int k);
    repeat (4) till(k, 2000);
  endtask
  function automatic logic [31:0] rccv(int s, d, b, pd, pw);
    return 32'h240 | d << 23 | b << 11 | pd << 13 | s << 4 | pw << 20;
  endfunction
  task automatic t_regs;
    apb(0, `SCTL_RCC_OFF, 0); chk(rd, `SCTL_RCC_RESET);
    apb(1, `SCTL_RCC_OFF, `SCTL_RCC_RESET | 32'h30000000); apb(0, `SCTL_RCC_OFF, 0);
    chk(rd, `SCTL_RCC_RESET | 32'h30000000); chk(slp, 2'h3);
    apb(0, `SCTL_LDOCTL_OFF, 0); chk(rd, 0);
    apb(0, 8'h40, 0); chk(err, 1);
    apb(1, `SCTL_LDOCTL_OFF, 32'hf); apb(0, `SCTL_LDOCTL_OFF, 0); chk(rd, 32'ha);
    chk(trim, 4'ha);
  endtask
  task automatic t_clk;
    int s[5] = '{0, 1, 2, 1, 1}, d[5] = '{3, 3, 3, 0, 3};
    int w[5] = '{0, 0, 0, 0, 1}, e[5] = '{24, 16, 64, 8, 32};
    for (int i = 0; i < 5; i++) begin
      apb(1, `SCTL_RCC_OFF, rccv(s[i], d[i], 1, 1, w[i]));
      per(w[i]); chk(p, e[i]);
    end
    apb(1, `SCTL_PGATE_OFF, 5); till(0, 200); chk(pEn, 8'h05);
  endtask
  task automatic t_wdt;
    apb(1, `SCTL_RCC_OFF, rccv(1, 0, 1, 1, 0));
    apb(1, `SCTL_WDLOAD_OFF, 32'd20); apb(1, `SCTL_WDCTL_OFF, 3);
    till(2, 1000); apb(1, `SCTL_WDSTAT_OFF, 1); #1 chk(wdtInt, 0);
    till(2, 1000); till(3, 400); chk(p >= 160 && p <= 176, 1);
    till(4, 100); chk(wdtInt, 0);
    apb(0, `SCTL_RESC_OFF, 0); chk(rd[0], 1);
    apb(1, `SCTL_WDCTL_OFF, 1); p = 0;
    repeat (520) begin @(posedge clk); #1; p += (intRst !== 1'b0); end
    chk(p, 0);
    apb(1, `SCTL_WDCTL_OFF, 0); apb(1, `SCTL_RESC_OFF, 3);
  endtask
  task automatic t_reg;
    @(posedge clk) regOutOfRange <= 1'b1;
    p = 0;
    repeat (30) begin @(posedge clk); #1; p += (intRst !== 1'b0); end
    chk(p, 0);
    apb(1, `SCTL_LDOCTL_OFF, 32'h100); till(3, 10); chk(p < 5, 1);
    @(posedge clk) regOutOfRange <= 1'b0;
    till(4, 100); apb(0, `SCTL_RESC_OFF, 0); chk(rd[1:0], 2'h2);
  endtask
  task automatic t_pll;
    apb(1, `SCTL_RCC_OFF, rccv(0, 3, 0, 0, 0));
    repeat (1000) @(posedge clk);
    #1 chk(pllReady, 0); chk(pllPowerDown, 0);
    chk(pllRef, 4'h9);
    per(0); chk(p, 24);
    till(5, 30000); chk(p > 26000, 1);
    per(0); chk(p, 16);
    per(6); chk(p, 48);
  endtask
  task automatic final_report;
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs; t_clk; t_wdt; t_reg; t_pll;
    final_report;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin n_mismatch++; final_report; end
  end
endmodule

// ==== tb/sctl_osc_model.sv ====
// oscillator and pll sources feeding the block pins
`timescale 1ns/100ps
module sctl_osc_model #(parameter MH = 3, IH = 2, PH = 2) (
  input wire logic clk,
  input wire logic pllPowerDown,
  output logic     mainOsc,
  output logic     intOsc,
  output logic     pllClk
);
  int cm = 0, ci = 0, cp = 0;
  initial {mainOsc, intOsc, pllClk} = 3'h0;
  // each source toggles after its half period; pll stands low while off
  always @(posedge clk) begin
    cm <= (cm + 1) % MH;
    ci <= (ci + 1) % IH;
    cp <= (cp + 1) % PH;
    if (cm == 0) mainOsc <= !mainOsc;
    if (ci == 0) intOsc <= !intOsc;
    pllClk <= pllPowerDown ? 1'b0 : pllClk ^ (cp == 0);
  end
endmodule
